// ### core/gpt_timer.sv
// Top of the 16-bit timer/counter with its AHB-Lite register slave.
`default_nettype none
module gpt_timer #(
  parameter int unsigned DATA_W = gpt_pkg::GPT_DATA_W,
  parameter int unsigned ADDR_W = gpt_pkg::GPT_ADDR_W
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic IDLE,
  input wire logic SLEEP,
  input wire logic EXT_CLOCK_GATE_PIN,
  output logic PERIOD_IRQ
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [DATA_W-1:0] count_q;
  logic [DATA_W-1:0] count_d;
  logic [DATA_W-1:0] period_q;
  logic [DATA_W-1:0] period_d;
  logic [DATA_W-1:0] control_q;
  logic [DATA_W-1:0] control_d;
  logic flag_q;
  logic flag_d;
  logic irq_en_q;
  logic irq_en_d;
  logic irq_out_q;

  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic pin_rise;
  logic pin_fall;

  logic accept;
  logic acc_read;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] wdata;
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_irq;

  logic timer_on;
  logic stop_in_idle;
  logic gated_accumulate_enable;
  logic external_sync_select;
  logic clock_source_select;
  gpt_pkg::gpt_div_t prescale_select;
  gpt_pkg::gpt_mode_t mode;

  logic idle_halt;
  logic sleep_halt;
  logic run;
  logic raw_tick;
  logic mode_tick;
  logic pre_tick;
  logic pre_clear;
  logic ton_falls;
  logic match;
  logic gate_end;
  logic flag_set;
  logic flag_clr;

  //////////////////////////////////////////////////////////////////////////
  // Register map decode

  // Read mux shared by the data phase register
  function automatic logic [31:0] read_mux(
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] cnt,
    input logic [DATA_W-1:0] per,
    input logic [DATA_W-1:0] ctl,
    input logic flg,
    input logic ien
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == gpt_pkg::GPT_ADDR_COUNT) begin
      r[DATA_W-1:0] = cnt;
    end else if (a == gpt_pkg::GPT_ADDR_PERIOD) begin
      r[DATA_W-1:0] = per;
    end else if (a == gpt_pkg::GPT_ADDR_CONTROL) begin
      r[DATA_W-1:0] = ctl;
    end else if (a == gpt_pkg::GPT_ADDR_IRQ) begin
      r[gpt_pkg::GPT_BIT_IRQ_FLAG] = flg;
      r[gpt_pkg::GPT_BIT_IRQ_EN] = ien;
    end
    return r;
  endfunction : read_mux

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  // Zero wait states, so the slave never stretches a transfer
  assign HREADYOUT = 1'b1;
  assign HRESP = gpt_pkg::GPT_HRESP_OKAY;
  assign HRDATA = rdata_q;

  // Address phase taken on NONSEQ with the bus ready
  assign accept = HSEL & HREADY & (HTRANS == gpt_pkg::GPT_HTRANS_NONSEQ);
  assign acc_read = accept & ~HWRITE;
  assign acc_addr = HADDR[ADDR_W-1:0];

  // Write strobes in the data phase, where HWDATA stands
  assign wdata = HWDATA[DATA_W-1:0];
  assign wr_count = wr_pend_q & (wr_addr_q == gpt_pkg::GPT_ADDR_COUNT);
  assign wr_period = wr_pend_q & (wr_addr_q == gpt_pkg::GPT_ADDR_PERIOD);
  assign wr_control = wr_pend_q & (wr_addr_q == gpt_pkg::GPT_ADDR_CONTROL);
  assign wr_irq = wr_pend_q & (wr_addr_q == gpt_pkg::GPT_ADDR_IRQ);

  // Read data sampled at the address phase; unmapped reads give zero
  assign rdata_d = acc_read ?
                   read_mux(acc_addr, count_q, period_q, control_q,
                            flag_q, irq_en_q) :
                   32'h0000_0000;

  // Address phase capture for the following write data phase
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= accept & HWRITE;
      wr_addr_q <= acc_addr;
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detection

  // Two flops before any logic; the third flop only serves the edge detect
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= EXT_CLOCK_GATE_PIN;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign pin_rise = pin_sync_q & ~pin_prev_q;
  assign pin_fall = ~pin_sync_q & pin_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // Control fields and mode decode

  assign timer_on = control_q[gpt_pkg::GPT_BIT_TIMER_ON];
  assign stop_in_idle = control_q[gpt_pkg::GPT_BIT_STOP_IN_IDLE];
  assign gated_accumulate_enable = control_q[gpt_pkg::GPT_BIT_GATED];
  assign external_sync_select = control_q[gpt_pkg::GPT_BIT_EXT_SYNC];
  assign clock_source_select = control_q[gpt_pkg::GPT_BIT_CLK_SRC];
  assign prescale_select = gpt_pkg::gpt_div_t'(
    control_q[gpt_pkg::GPT_BIT_PRE_HI:gpt_pkg::GPT_BIT_PRE_LO]);

  // Gating only applies with the internal source selected
  assign mode = clock_source_select ?
                (external_sync_select ? gpt_pkg::GPT_MODE_SYNC :
                                        gpt_pkg::GPT_MODE_ASYNC) :
                (gated_accumulate_enable ? gpt_pkg::GPT_MODE_GATED :
                                           gpt_pkg::GPT_MODE_TIMER); // see R7

  // Input tick per mode, before the prescaler
  always_comb begin
    mode_tick = 1'b0;
    unique case (mode)
      gpt_pkg::GPT_MODE_TIMER: mode_tick = 1'b1; // see R1
      gpt_pkg::GPT_MODE_GATED: mode_tick = pin_sync_q; // see R6
      gpt_pkg::GPT_MODE_SYNC: mode_tick = pin_rise; // see R3
      gpt_pkg::GPT_MODE_ASYNC: mode_tick = pin_rise; // see R4
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Run conditions for idle and sleep

  // Idle halts every mode when stop_in_idle is set, async included
  assign idle_halt = IDLE & stop_in_idle; // see R2 see R5
  // Sleep keeps only the on, external, asynchronous combination alive
  assign sleep_halt = SLEEP & (mode != gpt_pkg::GPT_MODE_ASYNC); // see R12
  assign run = timer_on & ~idle_halt & ~sleep_halt;
  // A halted timer delivers no ticks, so the prescaler stays frozen
  assign raw_tick = run & mode_tick; // see R10

  //////////////////////////////////////////////////////////////////////////
  // Prescaler

  // Clearing timer_on is seen as the control write that drops the bit
  assign ton_falls = wr_control & timer_on &
                     ~wdata[gpt_pkg::GPT_BIT_TIMER_ON];
  assign pre_clear = wr_count | ton_falls; // see R9

  gpt_prescale #(
    .PRE_W(gpt_pkg::GPT_PRE_W)
  ) u_prescale (
    .clk(CLK),
    .rstn(RSTN),
    .clear(pre_clear),
    .tick_in(raw_tick),
    .div_sel(prescale_select),
    .tick_out(pre_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Count and period

  // Match on the prescaled tick, count returning to zero on that tick
  assign match = pre_tick & (count_q == period_q); // see R20 see R13

  // Software write beats a tick in the same cycle
  assign count_d = wr_count ? wdata : // see R11
                   !pre_tick ? count_q :
                   match ? gpt_pkg::GPT_RST_COUNT : // see R1 see R3 see R4
                   count_q + gpt_pkg::GPT_COUNT_ONE;

  assign period_d = wr_period ? wdata : period_q;

  // Only defined bits are stored; the rest read as zero
  assign control_d = wr_control ? (wdata & gpt_pkg::GPT_CONTROL_MASK) :
                     control_q; // see R11

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      count_q <= gpt_pkg::GPT_RST_COUNT;
      period_q <= gpt_pkg::GPT_RST_PERIOD; // see R18
      control_q <= gpt_pkg::GPT_RST_CONTROL; // see R18
    end else begin
      count_q <= count_d;
      period_q <= period_d;
      control_q <= control_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt flag and request

  // Gate fall ends an accumulation interval; only while the timer is on
  assign gate_end = timer_on & (mode == gpt_pkg::GPT_MODE_GATED) &
                    pin_fall; // see R16
  assign flag_set = match | gate_end; // see R14
  // Write one to clear; hardware itself never clears the flag
  assign flag_clr = wr_irq & wdata[gpt_pkg::GPT_BIT_IRQ_FLAG]; // see R15
  // Set wins over a clear in the same cycle, so no event is lost
  assign flag_d = flag_set | (flag_q & ~flag_clr);
  assign irq_en_d = wr_irq ? wdata[gpt_pkg::GPT_BIT_IRQ_EN] : irq_en_q;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      irq_out_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_en_q <= irq_en_d;
      irq_out_q <= flag_d & irq_en_d; // see R17
    end
  end

  // Registered request, level until flag cleared or enable dropped
  assign PERIOD_IRQ = irq_out_q; // see R14 see R17

endmodule : gpt_timer
`default_nettype wire

// ### core/gpt_pkg.sv
// Constants, register map and mode types of the 16-bit timer/counter.
//
// How it works
// R1: Timer mode counts every clock cycle up to period, then restarts at zero.
// R2: Idle with stop_in_idle set halts timer, sync and gated counting.
// R3: Sync counter mode counts synchronised pin rises, wrapping at period.
// R4: Async counter mode counts every rising pin edge, wrapping after period.
// R5: Async counter stops in idle only when stop_in_idle is one.
// R6: Gated mode counts each clock cycle only while the gate pin is high.
// R7: Software enables gating with gate bit, timer_on, and internal source.
// R8: Selected input clock is divided by 1, 8, 64 or 256.
// R9: Prescaler clears on count write, on timer_on clearing, and on reset.
// R10: With the timer off the prescaler is frozen, not advanced.
// R11: Control writes leave the count alone; only count writes change it.
// R12: In sleep counting continues only if on, external and asynchronous.
// R13: Counting in sleep still wraps at period and may raise the request.
// R14: Count equal to period sets the flag; request goes out if enabled.
// R15: Software clears the flag; hardware never clears it.
// R16: Gated mode also sets the flag on the gate pin falling edge.
// R17: The request leaves the block only when period_irq_enable is set.
// R18: Reset loads period with all ones and control with all zeros.
// R19: Prescale codes 00, 01, 10, 11 mean divide by 1, 8, 64, 256.
// R20: Match falls on the tick where count equals period; count becomes zero.
`default_nettype none
package gpt_pkg;

  localparam int unsigned GPT_DATA_W = 16;
  localparam int unsigned GPT_ADDR_W = 12;
  localparam int unsigned GPT_PRE_W = 8;

  // Register indices as printed; byte address is four times the index
  localparam logic [GPT_ADDR_W-1:0] GPT_IDX_COUNT = 12'h100;
  localparam logic [GPT_ADDR_W-1:0] GPT_IDX_PERIOD = 12'h102;
  localparam logic [GPT_ADDR_W-1:0] GPT_IDX_CONTROL = 12'h104;
  localparam logic [GPT_ADDR_W-1:0] GPT_IDX_IRQ = 12'h106;
  localparam logic [GPT_ADDR_W-1:0] GPT_ADDR_COUNT = GPT_IDX_COUNT << 2;
  localparam logic [GPT_ADDR_W-1:0] GPT_ADDR_PERIOD = GPT_IDX_PERIOD << 2;
  localparam logic [GPT_ADDR_W-1:0] GPT_ADDR_CONTROL = GPT_IDX_CONTROL << 2;
  localparam logic [GPT_ADDR_W-1:0] GPT_ADDR_IRQ = GPT_IDX_IRQ << 2;

  // Field positions in timer_control
  localparam int unsigned GPT_BIT_TIMER_ON = 15;
  localparam int unsigned GPT_BIT_STOP_IN_IDLE = 13;
  localparam int unsigned GPT_BIT_GATED = 6;
  localparam int unsigned GPT_BIT_PRE_HI = 5;
  localparam int unsigned GPT_BIT_PRE_LO = 4;
  localparam int unsigned GPT_BIT_EXT_SYNC = 2;
  localparam int unsigned GPT_BIT_CLK_SRC = 1;
  localparam logic [GPT_DATA_W-1:0] GPT_CONTROL_MASK = 16'hA076;

  // Field positions in the interrupt register
  localparam int unsigned GPT_BIT_IRQ_FLAG = 0;
  localparam int unsigned GPT_BIT_IRQ_EN = 1;

  // Reset values
  localparam logic [GPT_DATA_W-1:0] GPT_RST_PERIOD = 16'hFFFF;
  localparam logic [GPT_DATA_W-1:0] GPT_RST_CONTROL = 16'h0000;
  localparam logic [GPT_DATA_W-1:0] GPT_RST_COUNT = 16'h0000;
  localparam logic [GPT_DATA_W-1:0] GPT_COUNT_ONE = 16'h0001;

  // Prescaler terminal counts (divide minus one)
  localparam logic [GPT_PRE_W-1:0] GPT_TERM_DIV1 = 8'h00;
  localparam logic [GPT_PRE_W-1:0] GPT_TERM_DIV8 = 8'h07;
  localparam logic [GPT_PRE_W-1:0] GPT_TERM_DIV64 = 8'h3F;
  localparam logic [GPT_PRE_W-1:0] GPT_TERM_DIV256 = 8'hFF;
  localparam logic [GPT_PRE_W-1:0] GPT_PRE_ONE = 8'h01;
  localparam logic [GPT_PRE_W-1:0] GPT_PRE_ZERO = 8'h00;

  // Prescale select codes
  typedef enum logic [1:0] {
    GPT_DIV1 = 2'b00,
    GPT_DIV8 = 2'b01,
    GPT_DIV64 = 2'b10,
    GPT_DIV256 = 2'b11
  } gpt_div_t;

  // Counting modes decoded from the control bits
  typedef enum logic [1:0] {
    GPT_MODE_TIMER = 2'b00,
    GPT_MODE_GATED = 2'b01,
    GPT_MODE_SYNC = 2'b10,
    GPT_MODE_ASYNC = 2'b11
  } gpt_mode_t;

  // AHB-Lite encodings
  localparam logic [1:0] GPT_HTRANS_NONSEQ = 2'b10;
  localparam logic GPT_HRESP_OKAY = 1'b0;

endpackage : gpt_pkg
`default_nettype wire

// ### core/gpt_prescale.sv
// Prescaler that divides the selected input tick by 1, 8, 64 or 256.
`default_nettype none
module gpt_prescale #(
  parameter int unsigned PRE_W = gpt_pkg::GPT_PRE_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic tick_in,
  input wire gpt_pkg::gpt_div_t div_sel,
  output logic tick_out
);

  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] cnt_d;
  logic [PRE_W-1:0] term;
  logic at_term;

  // Terminal count for each select code
  function automatic logic [PRE_W-1:0] term_of(input gpt_pkg::gpt_div_t s);
    logic [PRE_W-1:0] t;
    t = gpt_pkg::GPT_TERM_DIV1;
    unique case (s)
      gpt_pkg::GPT_DIV1: t = gpt_pkg::GPT_TERM_DIV1; // see R19
      gpt_pkg::GPT_DIV8: t = gpt_pkg::GPT_TERM_DIV8; // see R19
      gpt_pkg::GPT_DIV64: t = gpt_pkg::GPT_TERM_DIV64; // see R19
      gpt_pkg::GPT_DIV256: t = gpt_pkg::GPT_TERM_DIV256; // see R19
    endcase
    return t;
  endfunction : term_of

  // Divide: one output tick per term+1 input ticks
  assign term = term_of(div_sel);
  assign at_term = (cnt_q >= term);
  assign tick_out = tick_in & at_term; // see R8
  assign cnt_d = clear ? gpt_pkg::GPT_PRE_ZERO : // see R9
                 !tick_in ? cnt_q : // see R10
                 at_term ? gpt_pkg::GPT_PRE_ZERO :
                 cnt_q + gpt_pkg::GPT_PRE_ONE;

  // Counter holds whenever neither an input tick nor a clear arrives
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= gpt_pkg::GPT_PRE_ZERO; // see R9
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : gpt_prescale
`default_nettype wire

// ### tb/gpt_timer_monitor.sv
// Port checker for the timer's bus slave and interrupt request.
`default_nettype none
module gpt_timer_monitor (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic PERIOD_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // Bus history; enable is mirrored so the request can be judged
  wire logic take = HSEL && HREADY && HTRANS == gpt_pkg::GPT_HTRANS_NONSEQ;
  wire logic wr_irq = take && HWRITE && HADDR[11:0] == gpt_pkg::GPT_ADDR_IRQ;
  logic rd_q, wr_irq_q, en_q;
  logic [11:0] ra_q;
  wire logic mapped = ra_q == gpt_pkg::GPT_ADDR_COUNT ||
    ra_q == gpt_pkg::GPT_ADDR_PERIOD || ra_q == gpt_pkg::GPT_ADDR_CONTROL ||
    ra_q == gpt_pkg::GPT_ADDR_IRQ;
  // Mirror flops, all but ra_q cleared with the design's synchronous reset
  always_ff @(posedge CLK) begin
    rd_q <= RSTN && take && !HWRITE;
    wr_irq_q <= RSTN && wr_irq;
    ra_q <= HADDR[11:0];
    en_q <= !RSTN ? 1'b0 : (wr_irq_q ? HWDATA[1] : en_q);
  end
  ////////////////////////////////////////////////////////////
  // One clock domain, so clocking and disable are given once
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  AST_READY_ONE: assert property (HREADYOUT)
    else $error("slave inserted a wait state");
  AST_RESP_OKAY: assert property (!HRESP)
    else $error("slave gave an error response");
  AST_RDATA_QUIET: assert property (!rd_q |-> HRDATA == 32'h00000000)
    else $error("read data outside a read data phase");
  AST_UPPER_ZERO: assert property (rd_q |-> HRDATA[31:16] == 16'h0000)
    else $error("upper half of read data not zero");
  AST_UNMAPPED: assert property (rd_q && !mapped |-> HRDATA == 32'h00000000)
    else $error("unmapped read returned data");
  AST_CTL_RESERVED: assert property (
    rd_q && ra_q == gpt_pkg::GPT_ADDR_CONTROL
    |-> (HRDATA[15:0] & ~gpt_pkg::GPT_CONTROL_MASK) == 16'h0000)
    else $error("unused control bits read back set");
  AST_IRQ_REG: assert property (
    rd_q && ra_q == gpt_pkg::GPT_ADDR_IRQ
    |-> HRDATA[15:2] == 14'h0000 && HRDATA[1] == $past(en_q))
    else $error("interrupt register read wrong");
  AST_IRQ_NEEDS_EN: assert property (PERIOD_IRQ |-> en_q)
    else $error("request raised while disabled");
  AST_IRQ_HOLDS: assert property (
    $fell(PERIOD_IRQ) |-> $past(wr_irq_q))
    else $error("request dropped without a software write");
  AST_RST_QUIET: assert property (
    disable iff (1'b0) !RSTN |=> !PERIOD_IRQ && HRDATA == 32'h00000000)
    else $error("outputs not quiet after reset");
  COV_IRQ_RISE: cover property ($rose(PERIOD_IRQ));
  COV_IRQ_FALL: cover property ($fell(PERIOD_IRQ));
  COV_BAD_READ: cover property (rd_q && !mapped);
endmodule : gpt_timer_monitor

bind gpt_timer gpt_timer_monitor u_mon (
  .CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PERIOD_IRQ(PERIOD_IRQ)
);
`default_nettype wire

// ### tb/gpt_pin_src.sv
// Behavioural source for the external clock and gate pin.
`default_nettype none
module gpt_pin_src (
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin rests low between bursts, free of the bus clock's phase
  initial pin = 1'b0;
  // Burst of rising edges; a long half period models a slow source
  task automatic burst(input int n, input int half_ns);
    #25; // Keeps every pin edge clear of a clock edge
    repeat (n) begin
      #(half_ns);
      pin = 1'b1;
      #(half_ns);
      pin = 1'b0;
    end
  endtask : burst
  // Gate window; its falling edge ends the accumulation
  task automatic gate(input int len_ns);
    #25; // Off the clock edge, so the synchroniser sees no race
    pin = 1'b1;
    #(len_ns);
    pin = 1'b0;
  endtask : gate
endmodule : gpt_pin_src
`default_nettype wire

// ### tb/gpt_timer_tb.sv
// Self-checking bench: registers, prescaler, wrap, interrupt, pin modes.
`default_nettype none
module gpt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] a_cnt = {20'h00000, gpt_pkg::GPT_ADDR_COUNT};
  localparam logic [31:0] a_per = {20'h00000, gpt_pkg::GPT_ADDR_PERIOD};
  localparam logic [31:0] a_ctl = {20'h00000, gpt_pkg::GPT_ADDR_CONTROL};
  localparam logic [31:0] a_irq = {20'h00000, gpt_pkg::GPT_ADDR_IRQ};
  localparam logic [15:0] c_on = 16'h8000;
  localparam logic [15:0] c_sidl = 16'h2000;
  localparam logic [15:0] c_gate = 16'h0040;
  // Pin cases: control, sleep, idle, and whether counting must halt
  localparam logic [15:0] pc [7] = '{16'h0006, 16'h0002, 16'h0002,
    16'h0006, 16'h2002, 16'h0002, 16'h0000};
  localparam logic [6:0] p_sleep = 7'h4C;
  localparam logic [6:0] p_idle = 7'h30;
  localparam logic [6:0] p_halt = 7'h58;
  localparam int dv [4] = '{1, 8, 64, 256};
  logic clk, rstn, hwrite, idle, sleep, rd_live, hreadyout, hresp, irq, pin;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] r, c;
  logic [31:0] exp_q [$];
  int err_count, n_checks, i;
  ////////////////////////////////////////////////////////////
  gpt_timer DUT (
    .CLK(clk), .RSTN(rstn), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IDLE(idle),
    .SLEEP(sleep), .EXT_CLOCK_GATE_PIN(pin), .PERIOD_IRQ(irq)
  );
  gpt_pin_src u_src (.pin(pin));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic fail(input string m);
    $display("CHECK FAILED %0t %s", $time, m);
    err_count++;
  endtask : fail
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask : cmp
  task automatic cmp_irq(input logic exp);
    n_checks++;
    if (irq !== exp) fail($sformatf("request %b expected %b", irq, exp));
  endtask : cmp_irq
  // Bounded wait for ready; a hang ends the run
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 16) begin
        fail("bus hang");
        print_verdict();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  // One single transfer: address phase, then data phase
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= gpt_pkg::GPT_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rd_live <= !w;
    wait_rdy();
    rd_live <= 1'b0;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    bus(a, 1'b1, {16'h0000, d});
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    bus(a, 1'b0, 32'h00000000);
  endtask : rd
  // Timer on for the p-pulse pin burst plus n+3 clock cycles, then stops and clears prescaler
  task automatic run(input logic [15:0] ctl, input int n, input int p);
    wr(a_ctl, ctl);
    u_src.burst(p, 370);
    repeat (n) @(posedge clk);
    wr(a_ctl, 16'h0000);
  endtask : run
  // Watcher: read data taken at the data phase's closing edge
  always @(posedge clk) begin
    if (rd_live === 1'b1 && hreadyout === 1'b1) begin
      if (exp_q.size() == 0) fail("read with no note");
      else cmp(hrdata, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    {hwrite, idle, sleep, rd_live} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    err_count = 0;
    n_checks = 0;
    void'($urandom(35));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(a_per, 16'hFFFF);
    rd(a_ctl, 16'h0000);
    rd(a_irq, 16'h0000);
    rd(32'h00000414, 16'h0000);
    $display("test reset values done");
    // Random values; control writes keep the timer off
    r = 16'($urandom);
    c = 16'($urandom) & 16'h7FFF;
    wr(a_cnt, r);
    wr(a_per, ~r);
    wr(a_ctl, c);
    rd(a_cnt, r);
    rd(a_per, ~r);
    rd(a_ctl, c & gpt_pkg::GPT_CONTROL_MASK);
    $display("test register access done");
    // Every prescale code: run length gives three prescaled ticks
    wr(a_per, 16'hFFFF);
    for (i = 0; i < 4; i++) begin
      wr(a_cnt, 16'h0000);
      run(c_on | {10'h000, i[1:0], 4'h0}, 3 * dv[i] + dv[i] / 2 - 3, 0);
      rd(a_cnt, 16'h0003);
    end
    // No count write this time: dropping timer_on cleared the prescaler
    run(c_on | 16'h0010, 9, 0);
    rd(a_cnt, 16'h0004);
    $display("test prescaler done");
    // Twelve ticks against period 4 wrap twice
    wr(a_per, 16'h0004);
    wr(a_cnt, 16'h0000);
    run(c_on, 9, 0);
    rd(a_cnt, 16'h0002);
    rd(a_irq, 16'h0001);
    cmp_irq(1'b0);
    wr(a_irq, 16'h0002);
    repeat (3) @(posedge clk);
    cmp_irq(1'b1);
    rd(a_irq, 16'h0003);
    wr(a_irq, 16'h0001);
    repeat (3) @(posedge clk);
    cmp_irq(1'b0);
    rd(a_irq, 16'h0000);
    $display("test wrap and interrupt done");
    // Idle with and without stop_in_idle
    wr(a_per, 16'hFFFF);
    idle <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(a_cnt, 16'h0000);
      run(c_on | (i == 0 ? c_sidl : 16'h0000), 10, 0);
      rd(a_cnt, i == 0 ? 16'h0000 : 16'h000D);
    end
    $display("test idle done");
    // Pin modes under sleep and idle
    for (i = 0; i < 7; i++) begin
      sleep <= p_sleep[i];
      idle <= p_idle[i];
      wr(a_cnt, 16'h0000);
      run(c_on | pc[i], 6, 5);
      rd(a_cnt, p_halt[i] ? 16'h0000 : 16'h0005);
    end
    {sleep, idle} <= 2'h0;
    $display("test pin modes done");
    // Gated: no count with gate low, flag at gate fall
    wr(a_cnt, 16'h0000);
    run(c_on | c_gate, 20, 0);
    rd(a_cnt, 16'h0000);
    rd(a_irq, 16'h0000);
    wr(a_ctl, c_on | c_gate);
    u_src.gate(1000);
    repeat (6) @(posedge clk);
    rd(a_irq, 16'h0001);
    rd(a_cnt, 16'h000A);
    wr(a_ctl, 16'h0000);
    $display("test gated done");
    if (exp_q.size() != 0) fail("notes left unread");
    print_verdict();
  end
endmodule : gpt_timer_tb
`default_nettype wire
